// *** hw/ict_timing_core.sv ***
// cycle-count execution model for shift/rotate, bit, bit-field and
// conditional branch instructions
// assumes the decoder drives the request on mclk; add-on address time
// comes from the address stage already in clocks
`default_nettype none

// How it works
// - shift and rotate time never depends on the shift count
// - register shift by register count: 3 best, 6 otherwise, one prefetch in worst
// - memory single-position shift adds the effective-address fetch time
// - memory extend-rotate: 5 clocks one write, worst 6 with a prefetch
// - memory bit change/clear/set: 4 clocks one write, worst 5 plus prefetch
// - memory bit op with immediate number adds immediate-address fetch time
// - memory bit-field op adds immediate-address calculation time
// - field spanning five bytes needs two operand cycles, else one
// - memory field test under five bytes: 11 with read, worst 12
// - memory field invert/clear/set under five bytes: always 16 clocks
// - memory field extract under five bytes: 13 clocks, one read
// - memory field insert under five bytes: 14, worst 15 with prefetch
// - memory find-first-one under five bytes: 24 clocks, one read
// - decrement-branch false, count expired: 7 best, 10 otherwise
// - decrement-branch false, running: 3 best, 6 cache, 9 worst
// - branch figures are complete, nothing added
// - bus cycles lie inside the total clock count
module ict_timing_core #(
  parameter int ADD_W = 8,
  parameter int TOT_W = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic instValid,
  output logic instReady,
  input wire ict_pkg::ict_op_type opSel,
  input wire ict_pkg::ict_form_type formSel,
  input wire logic fieldSpan5,
  input wire logic overlapPrev,
  input wire logic cacheHit,
  input wire logic [ADD_W-1:0] addOnClocks,
  output logic busy,
  output logic donePulse,
  output logic rejectPulse,
  output logic [TOT_W-1:0] totalClocks_r,
  output ict_pkg::ict_case_type caseUsed_r,
  output logic [1:0] readCount_r,
  output logic [1:0] prefetchCount_r,
  output logic [1:0] writeCount_r,
  output logic busRead,
  output logic busPrefetch,
  output logic busWrite,
  output logic [31:0] instCount_r
);

  // ************************************************************
  // table lookup helpers
  // ************************************************************

  // row for register forms and for memory forms of the field
  // group; operand span only matters for fields
  function automatic ict_pkg::ict_row_type fieldRow(
    input ict_pkg::ict_form_type form, input logic span5,
    input ict_pkg::ict_row_type rReg, input ict_pkg::ict_row_type r4,
    input ict_pkg::ict_row_type r5);
    // five-byte span costs a second operand cycle
    if (form != ict_pkg::FORM_MEM)
      fieldRow = rReg;
    else if (span5)
      fieldRow = r5;
    else
      fieldRow = r4;
  endfunction

  function automatic ict_pkg::ict_row_type lookupRow(
    input ict_pkg::ict_op_type op, input ict_pkg::ict_form_type form,
    input logic span5);
    logic mem;
    mem = (form == ict_pkg::FORM_MEM);
    // no shift count reaches the table
    unique case (op)
      ict_pkg::OP_LOGICAL_SHIFT: begin
        if (form == ict_pkg::FORM_REG_DYNAMIC)
          lookupRow = ict_pkg::R_LSH_DY;
        else if (mem)
          lookupRow = ict_pkg::R_LSH_M;
        else
          lookupRow = ict_pkg::R_LSH_ST;
      end
      ict_pkg::OP_ARITH_SHIFT_LEFT:
        lookupRow = mem ? ict_pkg::R_ASL_M : ict_pkg::R_ASL_R;
      ict_pkg::OP_ARITH_SHIFT_RIGHT:
        lookupRow = mem ? ict_pkg::R_ASR_M : ict_pkg::R_ASR_R;
      ict_pkg::OP_ROTATE:
        lookupRow = mem ? ict_pkg::R_ROT_M : ict_pkg::R_ROT_R;
      ict_pkg::OP_EXTEND_ROTATE: begin
        // either direction shares one memory row
        lookupRow = mem ? ict_pkg::R_XRO_M : ict_pkg::R_XRO_R;
      end
      ict_pkg::OP_BIT_TEST:
        lookupRow = mem ? ict_pkg::R_BTS_M : ict_pkg::R_BTS_R;
      ict_pkg::OP_BIT_MODIFY: begin
        // invert, clear and set cost the same
        lookupRow = mem ? ict_pkg::R_BMO_M : ict_pkg::R_BMO_R;
      end
      ict_pkg::OP_FIELD_TEST: begin
        lookupRow = fieldRow(form, span5, ict_pkg::R_FTS_R,
                             ict_pkg::R_FTS_4, ict_pkg::R_FTS_5);
      end
      ict_pkg::OP_FIELD_MODIFY: begin
        lookupRow = fieldRow(form, span5, ict_pkg::R_FMO_R,
                             ict_pkg::R_FMO_4, ict_pkg::R_FMO_5);
      end
      ict_pkg::OP_FIELD_EXTRACT: begin
        lookupRow = fieldRow(form, span5, ict_pkg::R_FEX_R,
                             ict_pkg::R_FEX_4, ict_pkg::R_FEX_5);
      end
      ict_pkg::OP_FIELD_INSERT: begin
        lookupRow = fieldRow(form, span5, ict_pkg::R_FIN_R,
                             ict_pkg::R_FIN_4, ict_pkg::R_FIN_5);
      end
      ict_pkg::OP_FIELD_FIND_FIRST_ONE: begin
        lookupRow = fieldRow(form, span5, ict_pkg::R_FFO_R,
                             ict_pkg::R_FFO_4, ict_pkg::R_FFO_5);
      end
      ict_pkg::OP_BRANCH_TAKEN:
        lookupRow = ict_pkg::R_BR_TK;
      ict_pkg::OP_BRANCH_BYTE_NOT_TAKEN:
        lookupRow = ict_pkg::R_BR_BN;
      ict_pkg::OP_BRANCH_WORD_NOT_TAKEN:
        lookupRow = ict_pkg::R_BR_WN;
      ict_pkg::OP_BRANCH_LONG_NOT_TAKEN:
        lookupRow = ict_pkg::R_BR_LN;
      ict_pkg::OP_DECBR_RUNNING: begin
        lookupRow = ict_pkg::R_DB_RUN;
      end
      ict_pkg::OP_DECBR_EXPIRED: begin
        lookupRow = ict_pkg::R_DB_EXP;
      end
      ict_pkg::OP_DECBR_COND_TRUE:
        lookupRow = ict_pkg::R_DB_TRU;
      default:
        lookupRow = ict_pkg::R_NONE;
    endcase
  endfunction

  function automatic logic isBranch(input ict_pkg::ict_op_type op);
    isBranch = (op >= ict_pkg::OP_BRANCH_TAKEN) &&
               (op <= ict_pkg::OP_DECBR_COND_TRUE);
  endfunction

  function automatic logic isShift(input ict_pkg::ict_op_type op);
    isShift = (op <= ict_pkg::OP_EXTEND_ROTATE);
  endfunction

  // branches carry no operand; only the logical shift has a
  // register-count form; unknown codes are refused
  function automatic logic formLegal(
    input ict_pkg::ict_op_type op, input ict_pkg::ict_form_type form);
    if (op > ict_pkg::OP_DECBR_COND_TRUE)
      formLegal = 1'b0;
    else if (isBranch(op))
      formLegal = (form == ict_pkg::FORM_NONE);
    else if (form == ict_pkg::FORM_NONE)
      formLegal = 1'b0;
    else if (form == ict_pkg::FORM_REG_DYNAMIC)
      formLegal = (op == ict_pkg::OP_LOGICAL_SHIFT);
    else
      formLegal = 1'b1;
  endfunction

  // address-stage clocks apply only to memory operands
  function automatic logic addOnApplies(
    input ict_pkg::ict_op_type op, input ict_pkg::ict_form_type form);
    if (isBranch(op))
      addOnApplies = 1'b0;
    // shifts bit ops fields on memory add it
    else
      addOnApplies = (form == ict_pkg::FORM_MEM);
  endfunction

  // overlap beats cache hit, otherwise full prefetch
  function automatic ict_pkg::ict_case_type pickCase(
    input logic overlap, input logic hit);
    if (overlap)
      pickCase = ict_pkg::CASE_BEST;
    else if (hit)
      pickCase = ict_pkg::CASE_CACHE;
    else
      pickCase = ict_pkg::CASE_WORST;
  endfunction

  // ************************************************************
  // request decode
  // ************************************************************
  ict_pkg::ict_state_type state_r;
  ict_pkg::ict_row_type reqRow;
  ict_pkg::ict_cost_type reqCost;
  ict_pkg::ict_case_type reqCase;
  logic reqLegal;
  logic accept;
  logic refuse;
  logic [TOT_W-1:0] addOnPart;
  logic [TOT_W-1:0] totalClocks_nxt;
  logic [TOT_W-1:0] remain_r;

  always_comb begin
    reqRow = lookupRow(opSel, formSel, fieldSpan5);
    reqCase = pickCase(overlapPrev, cacheHit);
    reqCost = reqRow[reqCase];
    reqLegal = formLegal(opSel, formSel);
  end

  always_comb begin
    if (addOnApplies(opSel, formSel))
      addOnPart = TOT_W'(addOnClocks);
    else
      addOnPart = '0;
    // bus cycles are inside the listed figure, not added
    totalClocks_nxt = TOT_W'(reqCost.clocks) + addOnPart;
  end

  assign instReady = (state_r == ict_pkg::ST_IDLE);
  assign accept = instValid && instReady && reqLegal;
  assign refuse = instValid && instReady && !reqLegal;
  assign busy = (state_r == ict_pkg::ST_RUN);
  assign donePulse = busy && (remain_r == TOT_W'(1));

  // ************************************************************
  // execution countdown
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ict_pkg::ST_IDLE;
      remain_r <= '0;
    end else begin
      unique case (state_r)
        ict_pkg::ST_IDLE: begin
          if (accept) begin
            state_r <= ict_pkg::ST_RUN;
            remain_r <= totalClocks_nxt;
          end
        end
        ict_pkg::ST_RUN: begin
          remain_r <= remain_r - TOT_W'(1);
          if (remain_r == TOT_W'(1))
            state_r <= ict_pkg::ST_IDLE;
        end
        default: begin
          state_r <= ict_pkg::ST_IDLE;
          remain_r <= '0;
        end
      endcase
    end
  end

  // ************************************************************
  // result registers
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      totalClocks_r <= '0;
      caseUsed_r <= ict_pkg::CASE_BEST;
      readCount_r <= 2'h0;
      prefetchCount_r <= 2'h0;
      writeCount_r <= 2'h0;
    end else if (accept) begin
      totalClocks_r <= totalClocks_nxt;
      caseUsed_r <= reqCase;
      readCount_r <= reqCost.bus[5:4];
      prefetchCount_r <= reqCost.bus[3:2];
      writeCount_r <= reqCost.bus[1:0];
    end
  end

  // refusal is a registered one-cycle flag; no timing is started
  always_ff @(posedge mclk) begin
    if (rst)
      rejectPulse <= 1'b0;
    else
      rejectPulse <= refuse;
  end

  // wraps silently; a long-running count is only a statistic
  always_ff @(posedge mclk) begin
    if (rst)
      instCount_r <= 32'h0;
    else if (accept)
      instCount_r <= instCount_r + 32'h1;
  end

  // ************************************************************
  // bus cycle issue
  // ************************************************************
  // bus pulses start in the first busy clock, one per clock
  ict_bus_sequencer u_seq (
    .mclk(mclk),
    .rst(rst),
    .start(accept),
    .readNum(reqCost.bus[5:4]),
    .prefetchNum(reqCost.bus[3:2]),
    .writeNum(reqCost.bus[1:0]),
    .busRead(busRead),
    .busPrefetch(busPrefetch),
    .busWrite(busWrite)
  );

endmodule
`default_nettype wire

// *** hw/ict_pkg.sv ***
// shared types, cost tables and helpers for the instruction timing model
// assumes one clock domain; users reference everything as ict_pkg::name
`default_nettype none
package ict_pkg;

  // ************************************************************
  // operation, operand form and case codes
  // ************************************************************
  typedef enum logic [4:0] {
    OP_LOGICAL_SHIFT = 5'h00,
    OP_ARITH_SHIFT_LEFT = 5'h01,
    OP_ARITH_SHIFT_RIGHT = 5'h02,
    OP_ROTATE = 5'h03,
    OP_EXTEND_ROTATE = 5'h04,
    OP_BIT_TEST = 5'h05,
    OP_BIT_MODIFY = 5'h06,
    OP_FIELD_TEST = 5'h07,
    OP_FIELD_MODIFY = 5'h08,
    OP_FIELD_EXTRACT = 5'h09,
    OP_FIELD_INSERT = 5'h0a,
    OP_FIELD_FIND_FIRST_ONE = 5'h0b,
    OP_BRANCH_TAKEN = 5'h0c,
    OP_BRANCH_BYTE_NOT_TAKEN = 5'h0d,
    OP_BRANCH_WORD_NOT_TAKEN = 5'h0e,
    OP_BRANCH_LONG_NOT_TAKEN = 5'h0f,
    OP_DECBR_RUNNING = 5'h10,
    OP_DECBR_EXPIRED = 5'h11,
    OP_DECBR_COND_TRUE = 5'h12
  } ict_op_type;

  typedef enum logic [1:0] {
    FORM_REG_STATIC = 2'h0,
    FORM_REG_DYNAMIC = 2'h1,
    FORM_MEM = 2'h2,
    FORM_NONE = 2'h3
  } ict_form_type;

  typedef enum logic [1:0] {
    CASE_BEST = 2'h0,
    CASE_CACHE = 2'h1,
    CASE_WORST = 2'h2
  } ict_case_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } ict_state_type;

  // bus field holds read, prefetch, write counts, two bits each
  typedef struct packed {
    logic [7:0] clocks;
    logic [5:0] bus;
  } ict_cost_type;

  // index 0 best, 1 cache hit, 2 worst
  typedef ict_cost_type [2:0] ict_row_type;

  function automatic ict_row_type row(
    input logic [7:0] cb, input logic [7:0] cc, input logic [7:0] cw,
    input logic [5:0] bb, input logic [5:0] bc, input logic [5:0] bw);
    row = {{cw, bw}, {cc, bc}, {cb, bb}};
  endfunction

  // ************************************************************
  // cost rows: clocks best/cache/worst, then bus counts
  // ************************************************************
  localparam ict_row_type R_NONE = row(8'h01,8'h01,8'h01,6'h00,6'h00,6'h00);
  localparam ict_row_type R_LSH_ST = row(8'h01,8'h04,8'h04,6'h00,6'h00,6'h04);
  localparam ict_row_type R_LSH_DY = row(8'h03,8'h06,8'h06,6'h00,6'h00,6'h04);
  localparam ict_row_type R_LSH_M = row(8'h05,8'h05,8'h06,6'h01,6'h01,6'h05);
  localparam ict_row_type R_ASL_R = row(8'h05,8'h08,8'h08,6'h00,6'h00,6'h04);
  localparam ict_row_type R_ASL_M = row(8'h06,8'h06,8'h07,6'h01,6'h01,6'h05);
  localparam ict_row_type R_ASR_R = row(8'h03,8'h06,8'h06,6'h00,6'h00,6'h04);
  localparam ict_row_type R_ASR_M = row(8'h05,8'h05,8'h06,6'h01,6'h01,6'h05);
  localparam ict_row_type R_ROT_R = row(8'h05,8'h08,8'h08,6'h00,6'h00,6'h04);
  localparam ict_row_type R_ROT_M = row(8'h07,8'h07,8'h07,6'h01,6'h01,6'h05);
  localparam ict_row_type R_XRO_R = row(8'h09,8'h0c,8'h0c,6'h00,6'h00,6'h04);
  localparam ict_row_type R_XRO_M = row(8'h05,8'h05,8'h06,6'h01,6'h01,6'h05);
  localparam ict_row_type R_BTS_R = row(8'h01,8'h04,8'h05,6'h00,6'h00,6'h04);
  localparam ict_row_type R_BTS_M = row(8'h04,8'h04,8'h05,6'h00,6'h00,6'h04);
  localparam ict_row_type R_BMO_R = row(8'h01,8'h04,8'h05,6'h00,6'h00,6'h04);
  localparam ict_row_type R_BMO_M = row(8'h04,8'h04,8'h05,6'h01,6'h01,6'h05);
  localparam ict_row_type R_FTS_R = row(8'h03,8'h06,8'h07,6'h00,6'h00,6'h04);
  localparam ict_row_type R_FTS_4 = row(8'h0b,8'h0b,8'h0c,6'h10,6'h10,6'h14);
  localparam ict_row_type R_FTS_5 = row(8'h0f,8'h0f,8'h10,6'h20,6'h20,6'h24);
  localparam ict_row_type R_FMO_R = row(8'h09,8'h0c,8'h0c,6'h00,6'h00,6'h04);
  localparam ict_row_type R_FMO_4 = row(8'h10,8'h10,8'h10,6'h11,6'h11,6'h15);
  localparam ict_row_type R_FMO_5 = row(8'h18,8'h18,8'h18,6'h22,6'h22,6'h26);
  localparam ict_row_type R_FEX_R = row(8'h05,8'h08,8'h08,6'h00,6'h00,6'h04);
  localparam ict_row_type R_FEX_4 = row(8'h0d,8'h0d,8'h0d,6'h10,6'h10,6'h14);
  localparam ict_row_type R_FEX_5 = row(8'h12,8'h12,8'h12,6'h20,6'h20,6'h24);
  localparam ict_row_type R_FIN_R = row(8'h07,8'h0a,8'h0a,6'h00,6'h00,6'h04);
  localparam ict_row_type R_FIN_4 = row(8'h0e,8'h0e,8'h0f,6'h11,6'h11,6'h15);
  localparam ict_row_type R_FIN_5 = row(8'h14,8'h14,8'h15,6'h22,6'h22,6'h26);
  localparam ict_row_type R_FFO_R = row(8'h0f,8'h12,8'h12,6'h00,6'h00,6'h04);
  localparam ict_row_type R_FFO_4 = row(8'h18,8'h18,8'h18,6'h10,6'h10,6'h14);
  localparam ict_row_type R_FFO_5 = row(8'h20,8'h20,8'h20,6'h20,6'h20,6'h24);
  localparam ict_row_type R_BR_TK = row(8'h03,8'h06,8'h09,6'h00,6'h00,6'h08);
  localparam ict_row_type R_BR_BN = row(8'h01,8'h04,8'h05,6'h00,6'h00,6'h04);
  localparam ict_row_type R_BR_WN = row(8'h03,8'h06,8'h07,6'h00,6'h00,6'h04);
  localparam ict_row_type R_BR_LN = row(8'h03,8'h06,8'h09,6'h00,6'h00,6'h08);
  localparam ict_row_type R_DB_RUN = row(8'h03,8'h06,8'h09,6'h00,6'h00,6'h08);
  localparam ict_row_type R_DB_EXP = row(8'h07,8'h0a,8'h0a,6'h00,6'h00,6'h0c);
  localparam ict_row_type R_DB_TRU = row(8'h03,8'h06,8'h07,6'h00,6'h00,6'h04);

endpackage
`default_nettype wire

// *** hw/ict_bus_sequencer.sv ***
// issues the operand read, prefetch and write bus cycles of one instruction
// assumes start comes on the edge that loads the clock countdown
`default_nettype none
module ict_bus_sequencer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [1:0] readNum,
  input wire logic [1:0] prefetchNum,
  input wire logic [1:0] writeNum,
  output logic busRead,
  output logic busPrefetch,
  output logic busWrite
);

  logic [1:0] rdLeft_r;
  logic [1:0] pfLeft_r;
  logic [1:0] wrLeft_r;
  logic [1:0] rdNow;
  logic [1:0] pfNow;
  logic [1:0] wrNow;

  // a new start overrides leftovers; counts always fit inside the total
  always_comb begin
    rdNow = start ? readNum : rdLeft_r;
    pfNow = start ? prefetchNum : pfLeft_r;
    wrNow = start ? writeNum : wrLeft_r;
  end

  // ************************************************************
  // one bus cycle per clock: reads, then prefetches, then writes
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdLeft_r <= 2'h0;
      pfLeft_r <= 2'h0;
      wrLeft_r <= 2'h0;
      busRead <= 1'b0;
      busPrefetch <= 1'b0;
      busWrite <= 1'b0;
    end else begin
      rdLeft_r <= rdNow;
      pfLeft_r <= pfNow;
      wrLeft_r <= wrNow;
      busRead <= 1'b0;
      busPrefetch <= 1'b0;
      busWrite <= 1'b0;
      if (rdNow != 2'h0) begin
        rdLeft_r <= rdNow - 2'h1;
        busRead <= 1'b1;
      end else if (pfNow != 2'h0) begin
        pfLeft_r <= pfNow - 2'h1;
        busPrefetch <= 1'b1;
      end else if (wrNow != 2'h0) begin
        wrLeft_r <= wrNow - 2'h1;
        busWrite <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** verif/ict_timing_props.sv ***
// checker on the ports of the instruction timing core
// assumes one clock, synchronous reset; bound in at the foot of this file
`default_nettype none
module ict_timing_props #(
  parameter int TOT_W = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic instValid,
  input wire logic instReady,
  input wire logic overlapPrev,
  input wire logic cacheHit,
  input wire logic busy,
  input wire logic donePulse,
  input wire logic rejectPulse,
  input wire logic [TOT_W-1:0] totalClocks_r,
  input wire ict_pkg::ict_case_type caseUsed_r,
  input wire logic [1:0] readCount_r,
  input wire logic [1:0] prefetchCount_r,
  input wire logic [1:0] writeCount_r,
  input wire logic busRead,
  input wire logic busPrefetch,
  input wire logic busWrite,
  input wire logic [31:0] instCount_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // tallies of the running instruction
  // ********************
  // cleared while idle so every count starts at the first busy cycle
  logic [TOT_W-1:0] busyCnt_r;
  logic [2:0] rdCnt_r;
  logic [2:0] pfCnt_r;
  logic [2:0] wrCnt_r;
  always_ff @(posedge mclk) begin
    if (rst || !busy) begin
      busyCnt_r <= '0;
    end else begin
      busyCnt_r <= busyCnt_r + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst || !busy) begin
      rdCnt_r <= 3'h0;
      pfCnt_r <= 3'h0;
      wrCnt_r <= 3'h0;
    end else begin
      rdCnt_r <= rdCnt_r + {2'h0, busRead};
      pfCnt_r <= pfCnt_r + {2'h0, busPrefetch};
      wrCnt_r <= wrCnt_r + {2'h0, busWrite};
    end
  end
  // ********************
  // properties
  // ********************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence accept_s;
    instValid && instReady;
  endsequence
  sequence started_s;
    busy && !rejectPulse && !instReady;
  endsequence
  sequence refused_s;
    rejectPulse && !busy;
  endsequence
  take_or_refuse_a: assert property (
    accept_s |=> (started_s or refused_s))
    else $error("request neither started nor refused");
  ready_idle_a: assert property (instReady == !busy)
    else $error("ready and busy disagree");
  done_ends_a: assert property (
    donePulse |-> busy ##1 (!busy && instReady))
    else $error("done not in last busy cycle");
  busy_length_a: assert property (
    donePulse |-> (busyCnt_r + 1'b1) == totalClocks_r)
    else $error("busy length differs from total clocks");
  bus_inside_a: assert property (
    (busRead || busPrefetch || busWrite) |-> busy)
    else $error("bus cycle outside the instruction time");
  bus_counts_a: assert property (
    donePulse |-> (rdCnt_r + {2'h0, busRead}) == {1'b0, readCount_r}
      && (pfCnt_r + {2'h0, busPrefetch}) == {1'b0, prefetchCount_r}
      && (wrCnt_r + {2'h0, busWrite}) == {1'b0, writeCount_r})
    else $error("bus pulses differ from reported counts");
  one_pulse_a: assert property (
    $onehot0({busRead, busPrefetch, busWrite}))
    else $error("two bus cycles in one clock");
  case_pick_a: assert property (
    $rose(busy) |-> caseUsed_r == ($past(overlapPrev) ? ict_pkg::CASE_BEST
      : $past(cacheHit) ? ict_pkg::CASE_CACHE : ict_pkg::CASE_WORST))
    else $error("wrong case chosen");
  count_step_a: assert property (
    $rose(busy) |-> instCount_r == $past(instCount_r) + 32'h1)
    else $error("instruction count did not step");
endmodule
bind ict_timing_core ict_timing_props #(.TOT_W(TOT_W))
  u_ict_timing_props (.*);
`default_nettype wire

// *** verif/ict_bus_partner.sv ***
// memory and peripherals on the external bus, as seen by the core
// assumes one pulse per bus cycle; the core has no wait input, so
// every cycle completes at once and a slow reply cannot be shown
`default_nettype none
module ict_bus_partner (
  input wire logic mclk,
  input wire logic rst,
  input wire logic busRead,
  input wire logic busPrefetch,
  input wire logic busWrite,
  output logic [7:0] readsSeen,
  output logic [7:0] prefetchesSeen,
  output logic [7:0] writesSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // serviced bus cycles
  // ********************
  // tally served cycles
  always_ff @(posedge mclk) begin
    if (rst) begin
      readsSeen <= 8'h00;
      prefetchesSeen <= 8'h00;
      writesSeen <= 8'h00;
    end else begin
      readsSeen <= readsSeen + {7'h00, busRead};
      prefetchesSeen <= prefetchesSeen + {7'h00, busPrefetch};
      writesSeen <= writesSeen + {7'h00, busWrite};
    end
  end
endmodule
`default_nettype wire

// *** verif/ict_timing_core_bench.sv ***
// self-checking bench for the instruction timing core
// assumes the checker is bound in and the bus partner model is present
`default_nettype none
module ict_timing_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic instValid = 1'b0;
  ict_pkg::ict_op_type opSel = ict_pkg::OP_LOGICAL_SHIFT;
  ict_pkg::ict_form_type formSel = ict_pkg::FORM_NONE;
  logic fieldSpan5 = 1'b0;
  logic overlapPrev = 1'b0;
  logic cacheHit = 1'b0;
  logic [7:0] addOnClocks = 8'h00;
  logic instReady, busy, donePulse, rejectPulse;
  logic busRead, busPrefetch, busWrite;
  logic [9:0] totalClocks_r;
  ict_pkg::ict_case_type caseUsed_r;
  logic [1:0] readCount_r, prefetchCount_r, writeCount_r;
  logic [31:0] instCount_r;
  logic [7:0] readsSeen, prefetchesSeen, writesSeen;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 mclk = ~mclk;
  ict_timing_core #(.ADD_W(8), .TOT_W(10)) u_ict_timing_core (.*);
  ict_bus_partner u_ict_bus_partner (.*);
  // ********************
  // checking and closing
  // ********************
  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // about 45 instructions of at most 270 clocks each
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  // ********************
  // one instruction in each of best, cache and worst case
  // ********************
  // overlap is raised together with the hit to show its priority
  task automatic trio(input string nm, input ict_pkg::ict_op_type op,
      input ict_pkg::ict_form_type fm, input logic s5, input logic [7:0] ad,
      input int cb, cc, cw, rd, pw, wr);
    int n;
    int ex;
    logic [7:0] r0, p0, w0;
    for (int k = 0; k < 3; k++) begin
      while (instReady !== 1'b1) @(negedge mclk);
      r0 = readsSeen;
      p0 = prefetchesSeen;
      w0 = writesSeen;
      @(posedge mclk);
      instValid <= 1'b1;
      opSel <= op;
      formSel <= fm;
      fieldSpan5 <= s5;
      overlapPrev <= (k == 0);
      cacheHit <= (k != 2);
      addOnClocks <= ad;
      @(posedge mclk);
      instValid <= 1'b0;
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (donePulse !== 1'b1 && n < 300);
      ex = (k == 0) ? cb : (k == 1) ? cc : cw;
      ex += (fm == ict_pkg::FORM_MEM) ? int'(ad) : 0;
      @(negedge mclk);
      chk({nm, " clocks"}, n, ex);
      chk({nm, " total"}, totalClocks_r, ex);
      chk({nm, " case"}, caseUsed_r, k);
      chk({nm, " reads"}, readCount_r, rd);
      chk({nm, " prefetches"}, prefetchCount_r, (k == 2) ? pw : 0);
      chk({nm, " writes"}, writeCount_r, wr);
      chk({nm, " bus reads"}, readsSeen - r0, rd);
      chk({nm, " bus prefetches"}, prefetchesSeen - p0, (k == 2) ? pw : 0);
      chk({nm, " bus writes"}, writesSeen - w0, wr);
      chk({nm, " ready"}, instReady, 1);
    end
    $display("test %s done", nm);
  endtask
  task automatic refuse(input ict_pkg::ict_op_type op,
      input ict_pkg::ict_form_type fm);
    logic [31:0] c0;
    while (instReady !== 1'b1) @(negedge mclk);
    c0 = instCount_r;
    @(posedge mclk);
    instValid <= 1'b1;
    opSel <= op;
    formSel <= fm;
    @(posedge mclk);
    instValid <= 1'b0;
    @(negedge mclk);
    chk("refused pulse", rejectPulse, 1);
    chk("refused busy", busy, 0);
    @(negedge mclk);
    chk("refused count", instCount_r, c0);
    $display("test refuse done");
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic test_shift();
    trio("lsh static", ict_pkg::OP_LOGICAL_SHIFT, ict_pkg::FORM_REG_STATIC,
      1'b0, 8'h05, 1, 4, 4, 0, 1, 0);
    trio("lsh dynamic", ict_pkg::OP_LOGICAL_SHIFT, ict_pkg::FORM_REG_DYNAMIC,
      1'b0, 8'h05, 3, 6, 6, 0, 1, 0);
    trio("lsh mem", ict_pkg::OP_LOGICAL_SHIFT, ict_pkg::FORM_MEM,
      1'b0, 8'h02, 5, 5, 6, 0, 1, 1);
    trio("xrot mem", ict_pkg::OP_EXTEND_ROTATE, ict_pkg::FORM_MEM,
      1'b0, 8'h03, 5, 5, 6, 0, 1, 1);
  endtask
  task automatic test_bits();
    trio("bit mem", ict_pkg::OP_BIT_MODIFY, ict_pkg::FORM_MEM,
      1'b0, 8'h00, 4, 4, 5, 0, 1, 1);
    trio("bit mem add", ict_pkg::OP_BIT_MODIFY, ict_pkg::FORM_MEM,
      1'b0, 8'hff, 4, 4, 5, 0, 1, 1);
  endtask
  task automatic test_fields();
    trio("fld test", ict_pkg::OP_FIELD_TEST, ict_pkg::FORM_MEM,
      1'b0, 8'h00, 11, 11, 12, 1, 1, 0);
    trio("fld test5", ict_pkg::OP_FIELD_TEST, ict_pkg::FORM_MEM,
      1'b1, 8'h00, 15, 15, 16, 2, 1, 0);
    trio("fld modify", ict_pkg::OP_FIELD_MODIFY, ict_pkg::FORM_MEM,
      1'b0, 8'h06, 16, 16, 16, 1, 1, 1);
    trio("fld extract", ict_pkg::OP_FIELD_EXTRACT, ict_pkg::FORM_MEM,
      1'b0, 8'h01, 13, 13, 13, 1, 1, 0);
    trio("fld insert", ict_pkg::OP_FIELD_INSERT, ict_pkg::FORM_MEM,
      1'b0, 8'h00, 14, 14, 15, 1, 1, 1);
    trio("fld ffo", ict_pkg::OP_FIELD_FIND_FIRST_ONE, ict_pkg::FORM_MEM,
      1'b0, 8'h00, 24, 24, 24, 1, 1, 0);
  endtask
  task automatic test_branch();
    trio("dbr expired", ict_pkg::OP_DECBR_EXPIRED, ict_pkg::FORM_NONE,
      1'b0, 8'h07, 7, 10, 10, 0, 3, 0);
    trio("dbr running", ict_pkg::OP_DECBR_RUNNING, ict_pkg::FORM_NONE,
      1'b0, 8'h04, 3, 6, 9, 0, 2, 0);
    trio("br taken", ict_pkg::OP_BRANCH_TAKEN, ict_pkg::FORM_NONE,
      1'b0, 8'h09, 3, 6, 9, 0, 2, 0);
  endtask
  task automatic test_refuse();
    refuse(ict_pkg::OP_BRANCH_TAKEN, ict_pkg::FORM_MEM);
    refuse(ict_pkg::OP_FIELD_TEST, ict_pkg::FORM_NONE);
    refuse(ict_pkg::OP_ROTATE, ict_pkg::FORM_REG_DYNAMIC);
    refuse(ict_pkg::ict_op_type'(5'h13), ict_pkg::FORM_REG_STATIC);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    test_shift();
    test_bits();
    test_fields();
    test_branch();
    test_refuse();
    finish_test();
  end
endmodule
`default_nettype wire
